/* core/reset_timeout_sequencer.sv */
// Reset and start-up time-out sequencer with Wishbone register access
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer
    import rst_seq_pkg::*;
#(
    parameter int POWERUP_COUNT = POWERUP_CYCLES,
    parameter int OSC_COUNT = OSC_STARTUP_PERIODS,
    parameter int QUALIFY_COUNT = BROWNOUT_QUALIFY_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Analog detector and pin inputs
    input wire logic por_active_i,
    input wire logic brownout_below_i,
    input wire logic external_reset_pin_n_i,
    input wire logic osc_tick_i,
    // Configuration and core state
    input wire config_type cfg_i,
    input wire logic sleep_i,
    input wire logic wake_i,
    input wire logic erase_i,
    // Outputs
    output logic core_reset_o,
    output logic brownout_level_o,
    output logic brownout_armed_o,
    output logic resume_next_o,
    output logic irq_o
);
    // Three-stage synchronisers for pin and detector inputs
    logic [2:0] por_s_q, bor_s_q, pin_s_q, tick_s_q;
    logic por_q, bor_q, pin_n_q, tick_q, tick_prev_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_s_q <= 3'h7;
            bor_s_q <= 3'h0;
            pin_s_q <= 3'h0;
            tick_s_q <= 3'h0;
        end else if (ce_i) begin
            por_s_q <= {por_s_q[1:0], por_active_i};
            bor_s_q <= {bor_s_q[1:0], brownout_below_i};
            pin_s_q <= {pin_s_q[1:0], external_reset_pin_n_i};
            tick_s_q <= {tick_s_q[1:0], osc_tick_i};
        end
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_q <= 1'b1;
            bor_q <= 1'b0;
            pin_n_q <= 1'b0;
            tick_q <= 1'b0;
            tick_prev_q <= 1'b0;
        end else if (ce_i) begin
            if (por_s_q[1] == por_s_q[2]) por_q <= por_s_q[2];
            if (bor_s_q[1] == bor_s_q[2]) bor_q <= bor_s_q[2];
            if (pin_s_q[1] == pin_s_q[2]) pin_n_q <= pin_s_q[2];
            if (tick_s_q[1] == tick_s_q[2]) tick_q <= tick_s_q[2];
            tick_prev_q <= tick_q;
        end
    end

    // Brown-out enable decode, erase override and trip level
    wire en_always = (cfg_i.brownout_enable_sel == 2'h3);
    wire en_awake = (cfg_i.brownout_enable_sel == 2'h2) && !sleep_i;
    wire bor_active = en_always || en_awake || erase_i;
    wire level_sel = erase_i ? 1'b0 : cfg_i.brownout_level_sel;
    wire osc_edge = tick_q && !tick_prev_q;
    wire crystal = (cfg_i.osc_mode == OSC_CRYSTAL);
    wire powerup_timer_en = !cfg_i.powerup_timer_disable;

    // Qualifying filter on the brown-out comparator
    logic [15:0] qual_q;
    wire bor_trip = (qual_q >= 16'(QUALIFY_COUNT));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            qual_q <= 16'h0000;
        end else if (ce_i) begin
            if (!bor_q || !bor_active) qual_q <= 16'h0000;
            else if (!bor_trip) qual_q <= qual_q + 16'h0001;
        end
    end

    // Time-out sequencer
    seq_state_type state_q, state_d;
    logic [31:0] cnt_q, cnt_d;
    logic sleeping_q;
    wire powerup_timer_done = (cnt_q >= 32'(POWERUP_COUNT) - 32'h1);
    wire ost_done = (cnt_q >= 32'(OSC_COUNT) - 32'h1);
    seq_state_type after_powerup_timer;
    assign after_powerup_timer = crystal ? ST_OST : ST_RUN;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_HOLD: begin
                cnt_d = 32'h0;
                if (!por_q && !bor_trip) begin
                    state_d = powerup_timer_en ? ST_POWERUP_TIMER : after_powerup_timer;
                end
            end
            ST_POWERUP_TIMER: begin
                cnt_d = cnt_q + 32'h1;
                if (powerup_timer_done) begin
                    state_d = after_powerup_timer;
                    cnt_d = 32'h0;
                end
            end
            ST_OST, ST_WAKE: begin
                if (osc_edge) cnt_d = cnt_q + 32'h1;
                if (osc_edge && ost_done) begin
                    state_d = ST_RUN;
                    cnt_d = 32'h0;
                end
            end
            ST_RUN: begin
                cnt_d = 32'h0;
                if (sleeping_q && wake_i && crystal) state_d = ST_WAKE;
            end
            default: begin
                state_d = ST_HOLD;
                cnt_d = 32'h0;
            end
        endcase
        // A qualified brown-out trip (bor_trip) or power-on drops back and restarts timing
        if (por_q || bor_trip) begin
            state_d = ST_HOLD;
            cnt_d = 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_HOLD;
            cnt_q <= 32'h0;
        end else if (ce_i) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Sleep tracking for wake-up time-out
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleeping_q <= 1'b0;
        end else if (ce_i) begin
            if (wake_i) sleeping_q <= 1'b0;
            else if (sleep_i) sleeping_q <= 1'b1;
        end
    end

    // Core reset: timers run independent of the pin
    wire timers_busy = (state_q != ST_RUN) && (state_q != ST_WAKE);
    wire core_reset_d = por_q || bor_trip || !pin_n_q || timers_busy;
    wire wake_done = (state_q == ST_WAKE) && (state_d == ST_RUN);
    wire wake_fast = (state_q == ST_RUN) && sleeping_q && wake_i && !crystal;

    // Event detection
    logic core_reset_q;
    logic [EV_WIDTH-1:0] events;
    always_comb begin
        events = '0;
        events[EV_BOR] = bor_trip && (state_q != ST_HOLD);
        events[EV_RELEASE] = core_reset_q && !core_reset_d;
        events[EV_WAKE] = wake_done || wake_fast;
    end

    // Register bus decode
    wire bus_req = cyc_i && stb_i && !ack_o;
    wire wr = cyc_i && stb_i && ack_o && we_i && sel_i[0]; // Lands on the ack edge
    wire hit_cause = (adr_i == ADDR_CAUSE);
    wire hit_status = (adr_i == ADDR_STATUS);
    wire hit_clear = (adr_i == ADDR_CLEAR);
    wire hit_enable = (adr_i == ADDR_ENABLE);

    // Cause flags: hardware clear wins over software write
    logic [1:0] cause_q;
    logic [EV_WIDTH-1:0] status_q, enable_q;
    logic resume_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cause_q <= CAUSE_POR_VALUE;
        end else if (ce_i) begin
            if (wr && hit_cause) cause_q <= dat_i[1:0];
            if (por_q) cause_q[BIT_POR_FLAG] <= 1'b0;
            if (bor_trip && !por_q) cause_q[BIT_BOR_FLAG] <= 1'b0;
        end
    end

    // Sticky status, enable mask and interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= '0;
            enable_q <= '0;
        end else if (ce_i) begin
            if (wr && hit_clear) status_q <= (status_q & ~dat_i[EV_WIDTH-1:0]) | events;
            else status_q <= status_q | events;
            if (wr && hit_enable) enable_q <= dat_i[EV_WIDTH-1:0];
        end
    end

    // Read word selection
    wire [31:0] rd_word = hit_cause ? {30'h0, cause_q} :
        hit_status ? {29'h0, status_q} :
        hit_enable ? {29'h0, enable_q} : 32'h0;

    // Output registers and bus answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_reset_q <= 1'b1;
            resume_q <= 1'b0;
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else if (ce_i) begin
            core_reset_q <= core_reset_d;
            if (events[EV_WAKE]) resume_q <= 1'b1;
            else if (core_reset_d) resume_q <= 1'b0;
            ack_o <= bus_req;
            dat_o <= rd_word;
        end
    end

    assign core_reset_o = core_reset_q;
    assign brownout_level_o = level_sel;
    assign brownout_armed_o = bor_active;
    assign resume_next_o = resume_q;
    assign irq_o = |(status_q & enable_q);
endmodule
`default_nettype wire

/* core/rst_seq_pkg.sv */
// Package of constants and types for the reset time-out sequencer
package rst_seq_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_CAUSE = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_CLEAR = 4'h8;
    localparam logic [3:0] ADDR_ENABLE = 4'hC;
    // Cause register fields
    localparam int BIT_BOR_FLAG = 0;
    localparam int BIT_POR_FLAG = 1;
    localparam logic [1:0] CAUSE_POR_VALUE = 2'h1;
    // Event bits
    localparam int EV_BOR = 0;
    localparam int EV_RELEASE = 1;
    localparam int EV_WAKE = 2;
    localparam int EV_WIDTH = 3;
    // Timing
    localparam longint CLK_HZ = 25000000;
    localparam longint POWERUP_DELAY_MS = 64;
    localparam int POWERUP_CYCLES = int'((POWERUP_DELAY_MS * CLK_HZ) / 1000);
    localparam int OSC_STARTUP_PERIODS = 1024;
    localparam int BROWNOUT_QUALIFY_CYCLES = 4;
    // Oscillator modes
    typedef enum logic [1:0] {
        OSC_CRYSTAL = 2'h0,
        OSC_RESCAP = 2'h1,
        OSC_EXTCLK = 2'h2,
        OSC_INTERNAL = 2'h3
    } osc_mode_type;
    // Configuration bundle
    typedef struct packed {
        logic [1:0] brownout_enable_sel;
        logic brownout_level_sel;
        logic powerup_timer_disable;
        osc_mode_type osc_mode;
    } config_type;
    // Sequencer states
    typedef enum logic [4:0] {
        ST_HOLD = 5'h01,
        ST_POWERUP_TIMER = 5'h02,
        ST_OST = 5'h04,
        ST_RUN = 5'h08,
        ST_WAKE = 5'h10
    } seq_state_type;
endpackage

/* testbench/rst_seq_asserts.sv */
// Port checker for the reset time-out sequencer
`timescale 1ns/1ps
`default_nettype none
module rst_seq_asserts
    import rst_seq_pkg::*;
(
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic por_active_i,
    input wire logic external_reset_pin_n_i,
    input wire config_type cfg_i,
    input wire logic sleep_i,
    input wire logic erase_i,
    input wire logic core_reset_o,
    input wire logic brownout_level_o,
    input wire logic brownout_armed_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Bus request and its single-cycle answer
    sequence taken_s; cyc_i && stb_i && ce_i && !ack_o; endsequence
    sequence answer_s; ack_o ##1 !ack_o; endsequence
    bus_answer_a: assert property (taken_s |=> answer_s) else $error("ack not one cycle");
    reset_exit_a: assert property ($fell(rst_i) |-> core_reset_o)
        else $error("core left reset with bus reset");
    por_hold_a: assert property (por_active_i [*8] |-> core_reset_o)
        else $error("core runs during power-on");
    pin_hold_a: assert property (!external_reset_pin_n_i [*8] |-> core_reset_o)
        else $error("core runs with pin low");
    erase_arm_a: assert property (erase_i |-> brownout_armed_o && !brownout_level_o)
        else $error("erase not forcing detection");
    off_disarm_a: assert property (!erase_i && !cfg_i.brownout_enable_sel[1] |-> !brownout_armed_o)
        else $error("detection on while off");
    sleep_disarm_a: assert property (!erase_i && cfg_i.brownout_enable_sel == 2'h2 |->
        brownout_armed_o == !sleep_i) else $error("sleep mode arming wrong");
    always_arm_a: assert property (cfg_i.brownout_enable_sel == 2'h3 |-> brownout_armed_o)
        else $error("detection off in always mode");
    trip_level_a: assert property (!erase_i |-> brownout_level_o == cfg_i.brownout_level_sel)
        else $error("trip level wrong");
endmodule
bind reset_timeout_sequencer rst_seq_asserts chk (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o,
    .por_active_i, .external_reset_pin_n_i, .cfg_i, .sleep_i, .erase_i, .core_reset_o,
    .brownout_level_o, .brownout_armed_o);
`default_nettype wire

/* testbench/reset_timeout_sequencer_tb.sv */
// Self-checking bench for the reset time-out sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_timeout_sequencer_tb;
    import rst_seq_pkg::*;
    localparam int PU = 20;
    localparam int OC = 8;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic por = 1'b1, below = 1'b0, pin_n = 1'b1, sleep = 1'b0, wake = 1'b0, erase = 1'b0;
    logic ce = 1'b1;
    logic [1:0] div = 2'h0;
    logic [3:0] adr_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, core_rst, lvl, armed, resume, irq;
    config_type cfg = '{2'h3, 1'b0, 1'b0, OSC_CRYSTAL};
    int err_count = 0, tests_run = 0, seed = 32'hD115, n;
    logic [31:0] exp_q[$];
    osc_mode_type md[4] = '{OSC_CRYSTAL, OSC_CRYSTAL, OSC_RESCAP, OSC_EXTCLK};
    logic dis[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int lo[4] = '{PU + OC * 3, OC * 3, PU, 0};
    int hi[4] = '{PU + OC * 4 + 20, OC * 4 + 20, PU + 12, 12};
    // Clock and a slower oscillator
    always #20 clk_i = ~clk_i;
    always @(posedge clk_i) div <= div + 2'h1;
    reset_timeout_sequencer #(.POWERUP_COUNT(PU), .OSC_COUNT(OC)) DUT (.clk_i(clk_i),
        .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .por_active_i(por),
        .brownout_below_i(below), .external_reset_pin_n_i(pin_n), .osc_tick_i(div[1]),
        .cfg_i(cfg), .sleep_i(sleep), .wake_i(wake), .erase_i(erase), .core_reset_o(core_rst),
        .brownout_level_o(lvl), .brownout_armed_o(armed), .resume_next_o(resume), .irq_o(irq));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d of %0d checks", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Classic cycle; a read notes its expected word
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        if (!w) exp_q.push_back(d);
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_run;
        n = 0;
        while (core_rst !== 1'b0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    task automatic powerup(input config_type c, input int hold, input int l, input int h);
        cfg <= c;
        pin_n <= (hold == 0);
        por <= 1'b1;
        repeat (10) @(posedge clk_i);
        por <= 1'b0;
        repeat (hold) @(posedge clk_i);
        pin_n <= 1'b1;
        wait_run();
        check(n >= l && n <= h, 1);
    endtask
    // Read monitor takes the oldest note
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && !we_i && exp_q.size() > 0) check(dat_o, exp_q.pop_front());
    end
    initial begin
        #400000;
        err_count++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, ADDR_CAUSE, 32'h1);
        bus(1'b1, ADDR_ENABLE, 32'h7);
        for (int i = 0; i < 4; i++) begin
            powerup('{2'h3, 1'($random(seed)), dis[i], md[i]}, 0, lo[i], hi[i]);
        end
        powerup('{2'h3, 1'b0, 1'b0, OSC_CRYSTAL}, 120, 0, 8);
        bus(1'b1, ADDR_CAUSE, 32'h3);
        below <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(core_rst, 1);
        below <= 1'b0;
        repeat (12) @(posedge clk_i);
        below <= 1'b1;
        repeat (10) @(posedge clk_i);
        below <= 1'b0;
        wait_run();
        check(n >= PU + OC * 4 + 4, 1);
        bus(1'b0, ADDR_CAUSE, 32'h2);
        bus(1'b0, ADDR_STATUS, 32'h3);
        check(irq, 1);
        bus(1'b1, ADDR_CLEAR, 32'h7);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(irq, 0);
        bus(1'b1, ADDR_ENABLE, 32'h0);
        cfg.brownout_enable_sel <= 2'h2;
        sleep <= 1'b1;
        check(resume, 1'b0);
        @(posedge clk_i);
        wake <= 1'b1;
        @(posedge clk_i);
        wake <= 1'b0;
        repeat (20) @(posedge clk_i);
        check(resume, 1'b0);
        repeat (40) @(posedge clk_i);
        check(resume, 1);
        bus(1'b0, ADDR_STATUS, 32'h4);
        check(irq, 0);
        bus(1'b0, ADDR_CAUSE, 32'h2);
        erase <= 1'b1;
        repeat (3) @(posedge clk_i);
        erase <= 1'b0;
        cfg.brownout_enable_sel <= 2'h0;
        sleep <= 1'b0;
        bus(1'b0, 4'h2, 32'h0);
        // Clock enable low freezes the brown-out path
        cfg.brownout_enable_sel <= 2'h3;
        ce <= 1'b0;
        below <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(core_rst, 1'b0);
        ce <= 1'b1;
        repeat (12) @(posedge clk_i);
        check(core_rst, 1'b1);
        below <= 1'b0;
        wait_run();
        check(exp_q.size(), 0);
        end_sim();
    end
endmodule
`default_nettype wire
